// ---- rtl/kbrc_top.sv ----
// Keyboard controller route select register with APB access
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module kbrc_top
  import kbrc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [KBRC_ADDR_W-1:0] paddr,
  input  wire logic [KBRC_DATA_W-1:0] pwdata,
  output logic      [KBRC_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   aux_ctl_in,
  output logic                        aux_output_line,
  input  wire logic                   mouse_clk_pin,
  input  wire logic                   mouse_data_line,
  input  wire logic                   keybd_clk_pin,
  input  wire logic                   keybd_data_line,
  output logic                        core_mouse_clk,
  output logic                        core_mouse_data,
  output logic                        core_keybd_clk,
  output logic                        core_keybd_data,
  output logic                        mouse_wake_data,
  output logic                        keybd_wake_data,
  input  wire logic                   core_mouse_irq,
  input  wire logic                   core_keybd_irq,
  input  wire logic                   mouse_irq_ack,
  input  wire logic                   keybd_irq_ack,
  output logic                        mouse_irq,
  output logic                        keybd_irq,
  input  wire logic                   fast_reset_req,
  input  wire logic                   fast_gate_req,
  input  wire logic                   core_reset_req,
  input  wire logic                   core_gate_req,
  output logic                        fast_port_en,
  output logic                        cpu_reset_out,
  output logic                        addr_line_gate
);

  // Classify a bus address into route, reserved or unmapped
  function automatic kbrc_hit_type addr_class(input logic [KBRC_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[KBRC_IDX_MSB:KBRC_IDX_LSB];
    if (a[KBRC_ADDR_W-1:KBRC_IDX_MSB+1] != '0 || a[KBRC_IDX_LSB-1:0] != '0) begin
      addr_class = KBRC_HIT_NONE;
    end else if (idx == KBRC_ROUTE_IDX) begin
      addr_class = KBRC_HIT_ROUTE;
    end else if (idx >= KBRC_RSV_FIRST_IDX && idx <= KBRC_RSV_LAST_IDX) begin
      addr_class = KBRC_HIT_RSV;
    end else begin
      addr_class = KBRC_HIT_NONE;
    end
  endfunction

  logic [7:0]             route_reg;
  logic [KBRC_DATA_W-1:0] prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic                   aux_out_reg;
  logic                   core_mouse_clk_reg;
  logic                   core_mouse_data_reg;
  logic                   core_keybd_clk_reg;
  logic                   core_keybd_data_reg;
  logic                   mouse_wake_reg;
  logic                   keybd_wake_reg;
  logic                   fast_port_en_reg;
  logic                   cpu_reset_reg;
  logic                   addr_gate_reg;
  logic                   setup_phase;
  logic                   access_done;
  kbrc_hit_type           hit;
  logic [KBRC_NCH-1:0]    irq_live;
  logic [KBRC_NCH-1:0]    irq_ack;
  logic [KBRC_NCH-1:0]    irq_sel;
  logic [KBRC_NCH-1:0]    irq_out;

  // Bus phase decode
  assign hit         = addr_class(paddr);
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;

  // One wait-free access phase after every setup cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge clk) begin
    if (srst) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup_phase && (hit == KBRC_HIT_NONE);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_reg <= '0;
    end else if (setup_phase) begin
      if (hit == KBRC_HIT_ROUTE) begin
        prdata_reg <= {24'h000000, route_reg};
      end else begin
        prdata_reg <= '0;                      // Reserved and unmapped read zero
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      route_reg <= KBRC_ROUTE_RST;
    end else if (access_done && pwrite && hit == KBRC_HIT_ROUTE) begin
      route_reg <= pwdata[7:0] & KBRC_ROUTE_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aux_out_reg <= 1'b1;                     // Inactive for the default low polarity
    end else begin
      aux_out_reg <= route_reg[KBRC_AUX_POL_BIT] ? aux_ctl_in : !aux_ctl_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_mouse_clk_reg  <= KBRC_IDLE_LEVEL;
      core_mouse_data_reg <= KBRC_IDLE_LEVEL;
    end else if (route_reg[KBRC_M_ISO_BIT]) begin
      core_mouse_clk_reg  <= KBRC_IDLE_LEVEL;
      core_mouse_data_reg <= KBRC_IDLE_LEVEL;
    end else begin
      core_mouse_clk_reg  <= mouse_clk_pin;
      core_mouse_data_reg <= mouse_data_line;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_keybd_clk_reg  <= KBRC_IDLE_LEVEL;
      core_keybd_data_reg <= KBRC_IDLE_LEVEL;
    end else if (route_reg[KBRC_K_ISO_BIT]) begin
      core_keybd_clk_reg  <= KBRC_IDLE_LEVEL;
      core_keybd_data_reg <= KBRC_IDLE_LEVEL;
    end else begin
      core_keybd_clk_reg  <= keybd_clk_pin;
      core_keybd_data_reg <= keybd_data_line;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mouse_wake_reg <= KBRC_IDLE_LEVEL;
      keybd_wake_reg <= KBRC_IDLE_LEVEL;
    end else begin
      mouse_wake_reg <= mouse_data_line;
      keybd_wake_reg <= keybd_data_line;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fast_port_en_reg <= 1'b0;
      cpu_reset_reg    <= 1'b0;
      addr_gate_reg    <= 1'b0;
    end else begin
      fast_port_en_reg <= route_reg[KBRC_FAST_EN_BIT];
      cpu_reset_reg    <= core_reset_req | (route_reg[KBRC_FAST_EN_BIT] & fast_reset_req);
      addr_gate_reg    <= core_gate_req | (route_reg[KBRC_FAST_EN_BIT] & fast_gate_req);
    end
  end

  // Channel inputs gathered for the latch array
  assign irq_live[KBRC_CH_MOUSE] = core_mouse_irq;
  assign irq_live[KBRC_CH_KEYBD] = core_keybd_irq;
  assign irq_ack[KBRC_CH_MOUSE]  = mouse_irq_ack;
  assign irq_ack[KBRC_CH_KEYBD]  = keybd_irq_ack;
  assign irq_sel[KBRC_CH_MOUSE]  = route_reg[KBRC_M_LATCH_BIT];
  assign irq_sel[KBRC_CH_KEYBD]  = route_reg[KBRC_K_LATCH_BIT];

  for (genvar ch = 0; ch < KBRC_NCH; ch++) begin : g_irq
    kbrc_irq_latch u_latch (
      .clk        (clk),
      .srst       (srst),
      .irq_live   (irq_live[ch]),
      .irq_ack    (irq_ack[ch]),
      .latch_only (irq_sel[ch]),
      .irq_out    (irq_out[ch])
    );
  end

  // Output drive
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign aux_output_line = aux_out_reg;
  assign core_mouse_clk  = core_mouse_clk_reg;
  assign core_mouse_data = core_mouse_data_reg;
  assign core_keybd_clk  = core_keybd_clk_reg;
  assign core_keybd_data = core_keybd_data_reg;
  assign mouse_wake_data = mouse_wake_reg;
  assign keybd_wake_data = keybd_wake_reg;
  assign mouse_irq       = irq_out[KBRC_CH_MOUSE];
  assign keybd_irq       = irq_out[KBRC_CH_KEYBD];
  assign fast_port_en    = fast_port_en_reg;
  assign cpu_reset_out   = cpu_reset_reg;
  assign addr_line_gate  = addr_gate_reg;

  // Checks on the register and routing behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  aux_polarity_a: assert property (
    !$past(srst) |-> aux_output_line ==
      ($past(route_reg[KBRC_AUX_POL_BIT]) ? $past(aux_ctl_in) : !$past(aux_ctl_in)))
    else $error("aux output polarity wrong");

  mouse_block_a: assert property (
    route_reg[KBRC_M_ISO_BIT] |=> core_mouse_clk == KBRC_IDLE_LEVEL
                                  && core_mouse_data == KBRC_IDLE_LEVEL)
    else $error("mouse lines reach core while isolated");

  mouse_pass_a: assert property (
    !route_reg[KBRC_M_ISO_BIT] |=> core_mouse_data == $past(mouse_data_line)
                                   && core_mouse_clk == $past(mouse_clk_pin))
    else $error("mouse lines not passed to core");

  mouse_wake_a: assert property (
    !$past(srst) |-> mouse_wake_data == $past(mouse_data_line))
    else $error("mouse wake path lost data");

  keybd_block_a: assert property (
    route_reg[KBRC_K_ISO_BIT] |=> core_keybd_clk == KBRC_IDLE_LEVEL
                                  && core_keybd_data == KBRC_IDLE_LEVEL)
    else $error("keyboard lines reach core while isolated");

  keybd_pass_a: assert property (
    !route_reg[KBRC_K_ISO_BIT] |=> core_keybd_data == $past(keybd_data_line)
                                   && core_keybd_clk == $past(keybd_clk_pin))
    else $error("keyboard lines not passed to core");

  keybd_wake_a: assert property (
    !$past(srst) |-> keybd_wake_data == $past(keybd_data_line))
    else $error("keyboard wake path lost data");

  fast_off_a: assert property (
    !route_reg[KBRC_FAST_EN_BIT] |=> !fast_port_en
      && cpu_reset_out == $past(core_reset_req) && addr_line_gate == $past(core_gate_req))
    else $error("fast port acts while disabled");

  rsv_bits_a: assert property (
    route_reg[1:0] == 2'h0)
    else $error("reserved route bits hold state");

  route_write_a: assert property (
    access_done && pwrite && hit == KBRC_HIT_ROUTE
      |=> route_reg == ($past(pwdata[7:0]) & KBRC_ROUTE_WMASK))
    else $error("route write not stored");

  route_read_a: assert property (
    setup_phase && hit == KBRC_HIT_ROUTE |=> pready && !pslverr
      && prdata == {24'h000000, $past(route_reg)})
    else $error("route read data wrong");

  rsv_read_a: assert property (
    setup_phase && hit == KBRC_HIT_RSV |=> pready && !pslverr && prdata == '0)
    else $error("reserved index not read as zero");

  rsv_write_a: assert property (
    access_done && pwrite && hit != KBRC_HIT_ROUTE |=> $stable(route_reg))
    else $error("reserved write changed route register");

  // Bus answers one cycle after setup
  bus_answer_a: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

  fast_on_a: assert property (
    route_reg[KBRC_FAST_EN_BIT] |=> fast_port_en
      && cpu_reset_out == ($past(core_reset_req) || $past(fast_reset_req))
      && addr_line_gate == ($past(core_gate_req) || $past(fast_gate_req)))
    else $error("fast port ignored while enabled");

  // values at the first edge after reset
  reset_state_a: assert property (
    $past(srst) |-> route_reg == KBRC_ROUTE_RST && prdata == '0 && !pready && !pslverr
      && aux_output_line && !fast_port_en && !cpu_reset_out && !addr_line_gate
      && !mouse_irq && !keybd_irq)
    else $error("outputs not at reset values");

  // Unmapped address answers with an error
  unmapped_err_a: assert property (
    setup_phase && hit == KBRC_HIT_NONE |=> pready && pslverr && prdata == '0)
    else $error("unmapped address not refused");

  // Idle bus gives no answer
  bus_idle_a: assert property (
    !psel |=> !pready && !pslverr)
    else $error("answer without a request");

  // Read data holds until the next setup cycle
  prdata_hold_a: assert property (
    !setup_phase |=> $stable(prdata))
    else $error("read data changed without a setup");

  // Main scenarios reached
  route_wr_c: cover property (access_done && pwrite && hit == KBRC_HIT_ROUTE);
  rsv_rd_c:   cover property (access_done && !pwrite && hit == KBRC_HIT_RSV);
  iso_wake_c: cover property (route_reg[KBRC_M_ISO_BIT] && $changed(mouse_wake_data));
  fast_rst_c: cover property (fast_port_en && fast_reset_req ##1 cpu_reset_out);

endmodule // kbrc_top

// ---- shared/kbrc_pkg.sv ----
// Constants shared by the keyboard route configuration block
package kbrc_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] KBRC_ROUTE_IDX     = 8'hf0;
  localparam logic [7:0] KBRC_RSV_FIRST_IDX = 8'hf1;
  localparam logic [7:0] KBRC_RSV_LAST_IDX  = 8'hff;

  // Bus geometry
  localparam int         KBRC_ADDR_W        = 12;
  localparam int         KBRC_DATA_W        = 32;
  localparam int         KBRC_IDX_LSB       = 2;
  localparam int         KBRC_IDX_MSB       = 9;

  // Value after reset and the bits that hold state
  localparam logic [7:0] KBRC_ROUTE_RST     = 8'h00;
  localparam logic [7:0] KBRC_ROUTE_WMASK   = 8'hfc;

  // Field positions of the route select register
  localparam int         KBRC_AUX_POL_BIT   = 7;
  localparam int         KBRC_M_ISO_BIT     = 6;
  localparam int         KBRC_K_ISO_BIT     = 5;
  localparam int         KBRC_M_LATCH_BIT   = 4;
  localparam int         KBRC_K_LATCH_BIT   = 3;
  localparam int         KBRC_FAST_EN_BIT   = 2;

  // Level seen by the controller core on an isolated line
  localparam logic       KBRC_IDLE_LEVEL    = 1'b1;

  // Interrupt channels
  localparam int         KBRC_CH_MOUSE      = 0;
  localparam int         KBRC_CH_KEYBD      = 1;
  localparam int         KBRC_NCH           = 2;

  // Address decode classes
  typedef enum logic [1:0] {
    KBRC_HIT_NONE  = 2'h0,
    KBRC_HIT_ROUTE = 2'h1,
    KBRC_HIT_RSV   = 2'h2
  } kbrc_hit_type;

endpackage

// ---- rtl/kbrc_irq_latch.sv ----
// Interrupt latch and output select for one controller interrupt
`timescale 1ns/1ns
module kbrc_irq_latch
  import kbrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic irq_live,
  input  wire logic irq_ack,
  input  wire logic latch_only,
  output logic      irq_out
);

  logic live_d_reg;
  logic latch_reg;
  logic irq_out_reg;

  // Previous live level for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      live_d_reg <= 1'b0;
    end else begin
      live_d_reg <= irq_live;
    end
  end

  // Sticky copy; a new edge wins over a same-cycle ack
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_reg <= 1'b0;
    end else if (irq_live && !live_d_reg) begin
      latch_reg <= 1'b1;
    end else if (irq_ack) begin
      latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_out_reg <= 1'b0;
    end else begin
      irq_out_reg <= latch_only ? latch_reg : (latch_reg & irq_live);
    end
  end

  assign irq_out = irq_out_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  latch_sel_a: assert property (
    !$past(srst) |-> irq_out == ($past(latch_only) ? $past(latch_reg)
                                 : ($past(latch_reg) && $past(irq_live))))
    else $error("interrupt output does not follow latch select");

  latch_set_a: assert property (irq_live && !live_d_reg |=> latch_reg)
    else $error("interrupt edge not latched");

endmodule // kbrc_irq_latch

// ---- sim/kbrc_core_model.sv ----
// Behavioural model of the controller core behind the route block
`timescale 1ns/1ns
module kbrc_core_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [4:0] cmd,
  output logic            aux_ctl_in,
  output logic            core_mouse_irq,
  output logic            core_keybd_irq,
  output logic            core_reset_req,
  output logic            core_gate_req
);
  // Core levels change one edge after the bench asks, quiet in reset
  always_ff @(posedge clk) begin
    if (srst) begin
      {aux_ctl_in, core_mouse_irq, core_keybd_irq, core_reset_req, core_gate_req} <= 5'h00;
    end else begin
      {aux_ctl_in, core_mouse_irq, core_keybd_irq, core_reset_req, core_gate_req} <= cmd;
    end
  end
endmodule // kbrc_core_model

// ---- sim/kbrc_top_tb.sv ----
// Self-checking bench for the keyboard route configuration block
`timescale 1ns/1ns
module kbrc_top_tb
  import kbrc_pkg::*;
;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] pins;
    logic [4:0] cmd;
    logic [1:0] fast;
    logic [9:0] exp;
  } kbrc_row_type;

  logic                   clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [KBRC_ADDR_W-1:0] paddr;
  logic [KBRC_DATA_W-1:0] pwdata, prdata, rd;
  logic                   aux_ctl_in, aux_output_line, core_mouse_irq, core_keybd_irq;
  logic                   mouse_clk_pin, mouse_data_line, keybd_clk_pin, keybd_data_line;
  logic                   core_mouse_clk, core_mouse_data, core_keybd_clk, core_keybd_data;
  logic                   mouse_wake_data, keybd_wake_data, mouse_irq_ack, keybd_irq_ack;
  logic                   mouse_irq, keybd_irq, fast_reset_req, fast_gate_req;
  logic                   core_reset_req, core_gate_req, fast_port_en;
  logic                   cpu_reset_out, addr_line_gate;
  logic [4:0]             cmd;
  logic [11:0]            rsv_a [4] = '{12'h3c4, 12'h3fc, 12'h000, 12'h3c2};
  int                     failures, comparisons;
  wire  [9:0]             outs = {aux_output_line, core_mouse_clk, core_mouse_data,
                                  core_keybd_clk, core_keybd_data, mouse_wake_data,
                                  keybd_wake_data, fast_port_en, cpu_reset_out, addr_line_gate};

  // Config, pins, core request, fast request, expected port vector
  kbrc_row_type rows [6] = '{
    '{8'h00, 4'h5, 5'h10, 2'h3, 10'h0b8},
    '{8'h80, 4'ha, 5'h12, 2'h0, 10'h342},
    '{8'h40, 4'h0, 5'h01, 2'h0, 10'h381},
    '{8'h20, 4'h5, 5'h00, 2'h0, 10'h2f8},
    '{8'h64, 4'h0, 5'h10, 2'h2, 10'h1e6},
    '{8'h07, 4'hf, 5'h00, 2'h1, 10'h3fd}
  };

  kbrc_top dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_ctl_in(aux_ctl_in), .aux_output_line(aux_output_line),
    .mouse_clk_pin(mouse_clk_pin), .mouse_data_line(mouse_data_line),
    .keybd_clk_pin(keybd_clk_pin), .keybd_data_line(keybd_data_line),
    .core_mouse_clk(core_mouse_clk), .core_mouse_data(core_mouse_data),
    .core_keybd_clk(core_keybd_clk), .core_keybd_data(core_keybd_data),
    .mouse_wake_data(mouse_wake_data), .keybd_wake_data(keybd_wake_data),
    .core_mouse_irq(core_mouse_irq), .core_keybd_irq(core_keybd_irq),
    .mouse_irq_ack(mouse_irq_ack), .keybd_irq_ack(keybd_irq_ack),
    .mouse_irq(mouse_irq), .keybd_irq(keybd_irq),
    .fast_reset_req(fast_reset_req), .fast_gate_req(fast_gate_req),
    .core_reset_req(core_reset_req), .core_gate_req(core_gate_req),
    .fast_port_en(fast_port_en), .cpu_reset_out(cpu_reset_out),
    .addr_line_gate(addr_line_gate)
  );

  kbrc_core_model core (
    .clk(clk), .srst(srst), .cmd(cmd), .aux_ctl_in(aux_ctl_in),
    .core_mouse_irq(core_mouse_irq), .core_keybd_irq(core_keybd_irq),
    .core_reset_req(core_reset_req), .core_gate_req(core_gate_req)
  );

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic end_sim();
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Register value comparison
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  // Port level comparison
  task automatic chk_pin(input string n, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      failures++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Interrupt line of one channel
  function automatic logic [9:0] irq_of(input int ch);
    return {9'h0, ch == 1 ? keybd_irq : mouse_irq};
  endfunction

  // Main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
    {mouse_clk_pin, mouse_data_line, keybd_clk_pin, keybd_data_line} = 4'hf;
    {cmd, mouse_irq_ack, keybd_irq_ack, fast_reset_req, fast_gate_req} = 9'h0;
    repeat (3) @(posedge clk);
    chk_pin("reset outputs", 10'h3f8, outs);
    @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, 12'h3c0, 32'h0);
    chk_reg("route reset", 32'h0, rd);
    foreach (rows[r]) begin
      apb(1'b1, 12'h3c0, {24'h0, rows[r].cfg});
      {mouse_clk_pin, mouse_data_line, keybd_clk_pin, keybd_data_line} <= rows[r].pins;
      cmd <= rows[r].cmd;
      {fast_reset_req, fast_gate_req} <= rows[r].fast;
      repeat (4) @(posedge clk);
      chk_pin("route outputs", rows[r].exp, outs);
      apb(1'b0, 12'h3c0, 32'h0);
      chk_reg("route readback", {24'h0, rows[r].cfg & 8'hfc}, rd);
    end
    // Reserved and unmapped places take writes without effect
    apb(1'b1, 12'h3c0, 32'h0000_00a8);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, rsv_a[k], 32'hffff_ffff);
      apb(1'b0, rsv_a[k], 32'h0);
      chk_reg("reserved read", 32'h0, rd);
      chk_pin("bus error", {9'h0, k > 1}, {9'h0, err});
    end
    apb(1'b0, 12'h3c0, 32'h0);
    chk_reg("route kept", 32'h0000_00a8, rd);
    // Both interrupt channels in both output modes
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 2; m++) begin
        apb(1'b1, 12'h3c0, m == 0 ? 32'h0 : (ch == 1 ? 32'h8 : 32'h10));
        cmd <= ch == 1 ? 5'h04 : 5'h08;
        repeat (4) @(posedge clk);
        chk_pin("irq raised", 10'h1, irq_of(ch));
        cmd <= 5'h00;
        repeat (4) @(posedge clk);
        chk_pin("irq after drop", {9'h0, m == 1}, irq_of(ch));
        {keybd_irq_ack, mouse_irq_ack} <= ch == 1 ? 2'b10 : 2'b01;
        @(posedge clk);
        {keybd_irq_ack, mouse_irq_ack} <= 2'b00;
        repeat (3) @(posedge clk);
        chk_pin("irq after ack", 10'h0, irq_of(ch));
      end
    end
    // Second reset in mid-run clears the route register
    apb(1'b1, 12'h3c0, 32'h0000_00e4);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, 12'h3c0, 32'h0);
    chk_reg("route after reset", 32'h0, rd);
    chk_pin("outputs after reset", 10'h3f8, outs);
    end_sim();
  end
endmodule // kbrc_top_tb
